/* design/cke_keyboard_entry.sv */
// Console keyboard entry control with AXI4-Lite register slave
// Function
// (RQ1) Digits align left/right of decimal point
// (RQ2) Too many digits: error lamp and bell
// (RQ3) Numeric reset clears accumulator, error, restarts
// (RQ4) Alpha reset without error restarts, homes head
// (RQ5) Alpha reset with error only clears error
// (RQ6) Per-hundred sets flag, else error if disabled
// (RQ7) Per-thousand sets flag, else error if disabled
// (RQ8) Sign reverse marks negative, else error
// (RQ9) Four terminators end entry, set own flag
// (RQ10) Alpha request lights the alpha lamp
// (RQ11) Numeric keys rejected during typewriter entry; the four numeric terminators are accepted and end it
// (RQ12) Buffer overflow gives error and bell
// (RQ13) 32 plain keys, 17 shiftable keys
// (RQ14) Shift lock holds upper case until shift
// (RQ15) Left line advance moves form only
// (RQ16) Repeat except terminators and numeric digits
// (RQ17) Space moves carrier right when printing
// (RQ18) Unshifted backspace also steps memory back
// (RQ19) Shifted typewriter terminators become third, fourth
// (RQ20) Program select lamps; disabled key errors
// (RQ21) During error only RESET is accepted
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module cke_keyboard_entry
  import cke_pkg::*;
#(
  parameter int BUF_DEPTH  = BUF_DEPTH_DEF,
  parameter int REPEAT_CYC = REPEAT_CYC_DEF
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire cke_kbd_t     kbd_pins,
  output var cke_console_t  console,
  output logic [15:0]       psel_lamp
);

  localparam int IW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int PW = $clog2(BUF_DEPTH + 1);

  // AXI slave state
  logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic              aw_got_ff, w_got_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic [31:0]       rdata_ff, wdata_ff;
  logic [7:0]        awaddr_ff;
  logic [3:0]        wstrb_ff;
  // Block state
  logic [15:0]       ctrl_ff, psel_en_ff, psel_lamp_ff;
  cke_state_t        state_ff;
  cke_console_t      con_ff;
  cke_kbd_t          kb_s1_ff, kb_s2_ff;
  logic              kdown_d_ff, shift_d_ff;
  logic [31:0]       rep_cnt_ff, acc_ff;
  logic [3:0]        int_cnt_ff, frac_cnt_ff, term_ff, psel_idx_ff;
  logic              dec_ff, hund_ff, thou_ff, neg_ff, lock_ff, psel_hit_ff;
  logic [PW-1:0]     pos_ff;
  logic [IW-1:0]     buf_idx_ff;
  logic [7:0]        buf_mem [BUF_DEPTH];

  // Write channel bookkeeping; address and data may arrive in either order
  wire        aw_hs       = s_axi_awvalid & awready_ff;
  wire        w_hs        = s_axi_wvalid & wready_ff;
  wire        wr_fire     = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire        nxt_aw_got  = ~wr_fire & (aw_got_ff | aw_hs);
  wire        nxt_w_got   = ~wr_fire & (w_got_ff | w_hs);
  wire        nxt_bvalid  = wr_fire | (bvalid_ff & ~s_axi_bready);
  wire        ar_hs       = s_axi_arvalid & arready_ff;
  wire        nxt_rvalid  = ar_hs | (rvalid_ff & ~s_axi_rready);
  wire [31:0] wmask       = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                             {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] wmerged     = (wdata_ff & wmask) | ({16'h0000, ctrl_ff} & ~wmask);
  wire        wr_ctrl     = wr_fire & (awaddr_ff == ADDR_CTRL);
  wire        wr_psel     = wr_fire & (awaddr_ff == ADDR_PSEL);
  wire        wr_buf      = wr_fire & (awaddr_ff == ADDR_BUF);
  wire        wr_known    = (awaddr_ff == ADDR_CTRL) | (awaddr_ff == ADDR_STATUS) |
                            (awaddr_ff == ADDR_ACC) | (awaddr_ff == ADDR_PSEL) |
                            (awaddr_ff == ADDR_BUF);
  wire        sw_start    = wr_ctrl & wmerged[CTRL_START];
  wire [15:0] nxt_ctrl    = wr_ctrl ? wmerged[15:0] : ctrl_ff;

  // Control fields
  wire [1:0]  mode_new    = nxt_ctrl[CTRL_MODE_LSB +: 2];
  wire        cm_en       = ctrl_ff[CTRL_CM_EN];
  wire        srev_en     = ctrl_ff[CTRL_SREV_EN];
  wire        print_en    = ctrl_ff[CTRL_PRINT_EN];
  wire        mem_en      = ctrl_ff[CTRL_MEM_EN];
  wire        user_run    = ctrl_ff[CTRL_USER_RUN];
  wire [3:0]  int_lim     = ctrl_ff[CTRL_INT_LSB +: 4];
  wire [3:0]  frac_lim    = ctrl_ff[CTRL_FRAC_LSB +: 4];

  // Register read mux
  wire [31:0] status_word = {psel_idx_ff, 8'h00, frac_cnt_ff, int_cnt_ff, term_ff,
                             psel_hit_ff, lock_ff, neg_ff, thou_ff, hund_ff, dec_ff,
                             con_ff.error_lamp, (state_ff != ST_IDLE)};
  wire [31:0] buf_word    = {8'h00, 8'(pos_ff), 8'h00, buf_mem[buf_idx_ff]};
  wire        rd_known    = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_STATUS) |
                            (s_axi_araddr == ADDR_ACC) | (s_axi_araddr == ADDR_PSEL) |
                            (s_axi_araddr == ADDR_BUF);
  wire [31:0] rd_data     = (s_axi_araddr == ADDR_CTRL)   ? {16'h0000, ctrl_ff} :
                            (s_axi_araddr == ADDR_STATUS) ? status_word :
                            (s_axi_araddr == ADDR_ACC)    ? acc_ff :
                            (s_axi_araddr == ADDR_PSEL)   ? {16'h0000, psel_en_ff} :
                            (s_axi_araddr == ADDR_BUF)    ? buf_word : 32'h0000_0000;

  // AXI handshake registers; one write and one read in flight at most
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
    end else begin
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      bvalid_ff  <= nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
    end
  end

  // AXI payload registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bresp_ff  <= RESP_OKAY;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      if (aw_hs) awaddr_ff <= s_axi_awaddr;
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
      if (ar_hs) begin
        rdata_ff <= rd_data;
        rresp_ff <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Software registers; the start bit is a strobe and is not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff      <= CTRL_RST;
      psel_en_ff   <= PSEL_RST;
      psel_lamp_ff <= PSEL_RST;
      buf_idx_ff   <= '0;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      if (wr_psel) psel_en_ff <= (wdata_ff[15:0] & wmask[15:0]) | (psel_en_ff & ~wmask[15:0]);
      psel_lamp_ff <= psel_en_ff;                                  // [RQ20]
      if (wr_buf) buf_idx_ff <= wdata_ff[IW-1:0];
    end
  end

  // Keyboard pins pass two flops before anything looks at them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kb_s1_ff   <= '0;
      kb_s2_ff   <= '0;
      kdown_d_ff <= 1'b0;
      shift_d_ff <= 1'b0;
    end else begin
      kb_s1_ff   <= kbd_pins;
      kb_s2_ff   <= kb_s1_ff;
      kdown_d_ff <= kb_s2_ff.key_down;
      shift_d_ff <= kb_s2_ff.shift_held;
    end
  end

  // Key classification on the synchronised code
  wire [7:0]  code      = kb_s2_ff.key_code;
  wire        press     = kb_s2_ff.key_down & ~kdown_d_ff;
  wire        shift_rise = kb_s2_ff.shift_held & ~shift_d_ff;
  wire        k_digit   = code <= KEY_D000;
  wire        k_reset   = code == KEY_RESET;
  wire        k_nterm   = (code >= KEY_TERM1) & (code <= KEY_TERM4);
  wire        k_tterm   = (code == KEY_TW_TERM1) | (code == KEY_TW_TERM2);
  wire        k_term    = k_nterm | k_tterm;
  wire        k_numkb   = code < KEY_TW_BASE;
  wire        k_psel    = code[7:4] == KEY_PSEL_HI;
  wire        k_type    = (code >= KEY_TYPE_LO) & (code <= KEY_TYPE_HI);
  wire        k_store   = k_type | (code == KEY_SPACE);
  wire        upper     = kb_s2_ff.shift_held | lock_ff;
  // Terminators and numeric-keyboard digits never auto-repeat
  wire        rep_ok    = kb_s2_ff.key_down & kb_s2_ff.repeat_held & ~k_term & ~k_digit;
  wire        rep_fire  = rep_ok & (rep_cnt_ff == 32'(REPEAT_CYC - 1));   // [RQ16]
  wire        evt       = press | rep_fire;

  // Accept conditions; while the error lamp is lit only RESET gets through
  wire        err       = con_ff.error_lamp;
  wire        ev_reset  = evt & k_reset;
  wire        ok        = evt & ~err & ~k_reset & ~k_psel;                // [RQ21]
  wire        num_ok    = ok & (state_ff == ST_NUM);
  wire        alpha_ok  = ok & (state_ff == ST_ALPHA);

  // Digit counting: 00 and 000 count as two and three digits
  wire [1:0]  n_dig     = (code == KEY_D00) ? 2'd2 : (code == KEY_D000) ? 2'd3 : 2'd1;
  wire [3:0]  dig_val   = (code < KEY_D00) ? code[3:0] : 4'h0;
  wire [3:0]  cur_cnt   = dec_ff ? frac_cnt_ff : int_cnt_ff;
  wire [3:0]  cur_lim   = dec_ff ? frac_lim : int_lim;
  wire [4:0]  dig_sum   = {1'b0, cur_cnt} + {3'b000, n_dig};
  wire        dig_over  = dig_sum > {1'b0, cur_lim};
  wire        dig_take  = num_ok & k_digit & ~dig_over;
  wire [31:0] acc_dig   = (n_dig == 2'd1) ? {acc_ff[27:0], dig_val} :
                          (n_dig == 2'd2) ? {acc_ff[23:0], 8'h00} : {acc_ff[19:0], 12'h000};
  // Pad missing fraction digits so the point lands where the field wants it
  wire [3:0]  frac_pad  = frac_lim - frac_cnt_ff;
  wire [31:0] acc_align = acc_ff << {frac_pad, 2'b00};                    // [RQ1]

  // Error sources
  wire e_dig    = num_ok & k_digit & dig_over;                            // [RQ2]
  wire e_dec    = num_ok & (code == KEY_DEC) & dec_ff;
  wire e_cm     = num_ok & ((code == KEY_HUND) | (code == KEY_THOU)) & ~cm_en; // [RQ6] [RQ7]
  wire e_srev   = num_ok & (code == KEY_SREV) & ~srev_en;                 // [RQ8]
  wire e_numkb  = alpha_ok & k_numkb & ~k_nterm;                          // [RQ11]
  wire e_full   = alpha_ok & k_store & (pos_ff == PW'(BUF_DEPTH));        // [RQ12]
  wire e_psel   = evt & k_psel & ~psel_en_ff[code[3:0]] & user_run;       // [RQ20]
  wire set_err  = e_dig | e_dec | e_cm | e_srev | e_numkb | e_full | e_psel;
  wire nxt_err  = set_err | (err & ~ev_reset);

  // Entry sequencing
  wire restart_num   = ev_reset & (state_ff == ST_NUM);                   // [RQ3]
  wire restart_alpha = ev_reset & (state_ff == ST_ALPHA) & ~err;          // [RQ4] [RQ5]
  wire term_fire     = (num_ok | alpha_ok) & k_term;                      // [RQ9]
  wire [1:0] term_idx = k_nterm ? 2'(code - KEY_TERM1) :
                        {upper, code == KEY_TW_TERM2};                    // [RQ19]
  wire [7:0] char_in = (code >= KEY_SHIFT_LO && k_type && upper) ? (code | CHAR_UPPER) : code;
  wire buf_we    = alpha_ok & k_store & ~e_full;
  wire bksp      = alpha_ok & (code == KEY_BKSP);
  wire mem_back  = bksp & ~upper & mem_en & (pos_ff != '0);               // [RQ18]

  // Repeat interval counter
  always_ff @(posedge aclk) begin
    if (!aresetn || press || !rep_ok || rep_fire) rep_cnt_ff <= 32'h0000_0000;
    else rep_cnt_ff <= rep_cnt_ff + 32'h0000_0001;
  end

  // Entry state: software start opens it, a terminator closes it
  always_ff @(posedge aclk) begin
    if (!aresetn) state_ff <= ST_IDLE;
    else if (sw_start) begin
      case (mode_new)
        2'b01:   state_ff <= ST_NUM;
        2'b10:   state_ff <= ST_ALPHA;
        default: state_ff <= ST_IDLE;
      endcase
    end else if (term_fire) state_ff <= ST_IDLE;
  end

  // Numeric accumulator and digit counts
  always_ff @(posedge aclk) begin
    if (!aresetn || sw_start || restart_num) begin                        // [RQ3]
      acc_ff      <= 32'h0000_0000;
      int_cnt_ff  <= 4'h0;
      frac_cnt_ff <= 4'h0;
      dec_ff      <= 1'b0;
    end else if (dig_take) begin                                          // [RQ1]
      acc_ff <= acc_dig;
      if (dec_ff) frac_cnt_ff <= dig_sum[3:0];
      else int_cnt_ff <= dig_sum[3:0];
    end else if (num_ok && code == KEY_DEC) dec_ff <= 1'b1;
    else if (term_fire && state_ff == ST_NUM) begin
      acc_ff      <= acc_align;
      frac_cnt_ff <= frac_lim;
    end
  end

  // Program-visible flags; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hund_ff     <= 1'b0;
      thou_ff     <= 1'b0;
      neg_ff      <= 1'b0;
      term_ff     <= 4'h0;
      psel_hit_ff <= 1'b0;
      psel_idx_ff <= 4'h0;
    end else begin
      if (sw_start || restart_num) begin
        hund_ff <= 1'b0;
        thou_ff <= 1'b0;
        neg_ff  <= 1'b0;
      end
      if (sw_start) begin
        term_ff     <= 4'h0;
        psel_hit_ff <= 1'b0;
      end
      if (num_ok && code == KEY_HUND && cm_en) hund_ff <= 1'b1;           // [RQ6]
      if (num_ok && code == KEY_THOU && cm_en) thou_ff <= 1'b1;           // [RQ7]
      if (num_ok && code == KEY_SREV && srev_en) neg_ff <= 1'b1;          // [RQ8]
      if (term_fire) term_ff <= 4'h1 << term_idx;                         // [RQ9]
      if (evt && k_psel && !err && !e_psel) begin
        psel_hit_ff <= 1'b1;
        psel_idx_ff <= code[3:0];
      end
    end
  end

  // Shift lock: the lock key sets it, a shift key press cancels it
  always_ff @(posedge aclk) begin
    if (!aresetn || shift_rise) lock_ff <= 1'b0;                          // [RQ14]
    else if (evt && !err && code == KEY_SHLOCK) lock_ff <= 1'b1;
  end

  // Keyboard buffer position; RESET restart overwrites earlier data
  always_ff @(posedge aclk) begin
    if (!aresetn || sw_start || restart_alpha) pos_ff <= '0;              // [RQ4]
    else if (buf_we) pos_ff <= pos_ff + PW'(1);
    else if (mem_back) pos_ff <= pos_ff - PW'(1);                         // [RQ18]
  end

  // Buffer storage has no reset; software can select and read back any slot, written or not
  always_ff @(posedge aclk) begin
    if (buf_we) buf_mem[pos_ff[IW-1:0]] <= char_in;                       // [RQ13]
  end

  // Lamps, bell and one-cycle mechanism strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) con_ff <= '0;
    else begin
      con_ff.error_lamp    <= nxt_err;                                    // [RQ2] [RQ5]
      con_ff.alarm_bell    <= nxt_err;
      con_ff.alpha_lamp    <= state_ff == ST_ALPHA;                       // [RQ10]
      con_ff.numeric_lamp  <= state_ff == ST_NUM;
      con_ff.form_advance  <= evt & ~err & (code == KEY_LF_LEFT);         // [RQ15]
      con_ff.carrier_right <= alpha_ok & (code == KEY_SPACE) & print_en;  // [RQ17]
      con_ff.carrier_left  <= bksp & print_en;
      con_ff.head_home     <= restart_alpha;                              // [RQ4]
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign console       = con_ff;
  assign psel_lamp     = psel_lamp_ff;

  // Checks on the entry behaviour
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_digit_over;
    e_dig |=> console.error_lamp && console.alarm_bell && $stable(acc_ff);
  endproperty
  a_digit_over: assert property (p_digit_over) else $error("digit overflow not flagged"); // [RQ2]

  property p_num_reset;
    restart_num && !sw_start |=> acc_ff == 32'h0 && !console.error_lamp && state_ff == ST_NUM;
  endproperty
  a_num_reset: assert property (p_num_reset) else $error("numeric reset wrong"); // [RQ3]

  property p_alpha_restart;
    restart_alpha && !sw_start |=> console.head_home && pos_ff == '0 ##1 !console.head_home;
  endproperty
  a_alpha_restart: assert property (p_alpha_restart) else $error("alpha restart wrong"); // [RQ4]

  property p_alpha_err_reset;
    ev_reset && state_ff == ST_ALPHA && err |=> !console.error_lamp && !console.head_home
      && $stable(pos_ff);
  endproperty
  a_alpha_err_reset: assert property (p_alpha_err_reset) else $error("error reset moved head"); // [RQ5]

  property p_cm_disabled;
    num_ok && (code == KEY_HUND || code == KEY_THOU) && !cm_en
      |=> console.error_lamp && !$rose(hund_ff) && !$rose(thou_ff);
  endproperty
  a_cm_disabled: assert property (p_cm_disabled) else $error("disabled C/M accepted"); // [RQ6]

  property p_sign_rev;
    num_ok && code == KEY_SREV |=> srev_en ? neg_ff : console.error_lamp;
  endproperty
  a_sign_rev: assert property (p_sign_rev) else $error("sign reverse wrong"); // [RQ8]

  property p_term;
    term_fire && !sw_start |=> state_ff == ST_IDLE && $onehot(term_ff) ##1 !console.alpha_lamp
      && !console.numeric_lamp;
  endproperty
  a_term: assert property (p_term) else $error("terminator did not end entry"); // [RQ9]

  property p_alpha_lamp;
    state_ff == ST_ALPHA |=> console.alpha_lamp;
  endproperty
  a_alpha_lamp: assert property (p_alpha_lamp) else $error("alpha lamp off"); // [RQ10]

  property p_numkb_reject;
    e_numkb |=> console.error_lamp && $stable(pos_ff) && state_ff == ST_ALPHA;
  endproperty
  a_numkb_reject: assert property (p_numkb_reject) else $error("numeric key in alpha"); // [RQ11]

  property p_buf_full;
    alpha_ok && k_store && pos_ff == PW'(BUF_DEPTH) |=> console.error_lamp && $stable(pos_ff);
  endproperty
  a_buf_full: assert property (p_buf_full) else $error("buffer overflow missed"); // [RQ12]

  property p_err_discard;
    err && evt && !k_reset && !sw_start |=> $stable(acc_ff) && $stable(pos_ff)
      && $stable(term_ff);
  endproperty
  a_err_discard: assert property (p_err_discard) else $error("data taken during error"); // [RQ21]

  property p_bksp_shifted;
    bksp && upper && !sw_start |=> $stable(pos_ff);
  endproperty
  a_bksp_shifted: assert property (p_bksp_shifted) else $error("shifted backspace moved"); // [RQ18]

  c_num_entry: cover property (state_ff == ST_NUM ##1 term_fire);
  c_alpha_err: cover property (e_numkb ##[1:50] restart_alpha);
  c_repeat:    cover property (rep_fire && alpha_ok && k_type);

endmodule // cke_keyboard_entry

`default_nettype wire

/* include/cke_pkg.sv */
// Shared constants and types for the console keyboard entry control
package cke_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ACC    = 8'h08;
  localparam logic [7:0] ADDR_PSEL   = 8'h0c;
  localparam logic [7:0] ADDR_BUF    = 8'h10;

  // Control register layout and reset value
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CM_EN    = 2;
  localparam int CTRL_SREV_EN  = 3;
  localparam int CTRL_PRINT_EN = 4;
  localparam int CTRL_MEM_EN   = 5;
  localparam int CTRL_USER_RUN = 6;
  localparam int CTRL_INT_LSB  = 8;
  localparam int CTRL_FRAC_LSB = 12;
  localparam int CTRL_START    = 31;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PSEL_RST = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Key codes as delivered on the key code pins
  localparam logic [7:0] KEY_D00      = 8'h0a;
  localparam logic [7:0] KEY_D000     = 8'h0b;
  localparam logic [7:0] KEY_DEC      = 8'h0c;
  localparam logic [7:0] KEY_RESET    = 8'h0d;
  localparam logic [7:0] KEY_HUND     = 8'h0e;
  localparam logic [7:0] KEY_THOU     = 8'h0f;
  localparam logic [7:0] KEY_SREV     = 8'h10;
  localparam logic [7:0] KEY_TERM1    = 8'h11;
  localparam logic [7:0] KEY_TERM4    = 8'h14;
  localparam logic [7:0] KEY_TW_BASE  = 8'h20;
  localparam logic [7:0] KEY_SPACE    = 8'h20;
  localparam logic [7:0] KEY_BKSP     = 8'h21;
  localparam logic [7:0] KEY_LF_LEFT  = 8'h22;
  localparam logic [7:0] KEY_SHLOCK   = 8'h24;
  localparam logic [7:0] KEY_TW_TERM1 = 8'h25;
  localparam logic [7:0] KEY_TW_TERM2 = 8'h26;
  localparam logic [3:0] KEY_PSEL_HI  = 4'h3;
  localparam logic [7:0] KEY_TYPE_LO  = 8'h40;
  localparam logic [7:0] KEY_SHIFT_LO = 8'h60;
  localparam logic [7:0] KEY_TYPE_HI  = 8'h70;
  localparam logic [7:0] CHAR_UPPER   = 8'h80;

  // Timing: repeat interval while a repeat key is held
  localparam int CLK_HZ         = 10_000_000;
  localparam int REPEAT_MS      = 100;
  localparam int REPEAT_CYC_DEF = REPEAT_MS * (CLK_HZ / 1000);
  localparam int BUF_DEPTH_DEF  = 64;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_NUM   = 2'b01,
    ST_ALPHA = 2'b10
  } cke_state_t;

  // Keyboard pins, asynchronous to aclk
  typedef struct packed {
    logic       key_down;
    logic [7:0] key_code;
    logic       shift_held;
    logic       repeat_held;
  } cke_kbd_t;

  // Console lamps, bell and mechanism strobes
  typedef struct packed {
    logic error_lamp;
    logic alarm_bell;
    logic alpha_lamp;
    logic numeric_lamp;
    logic form_advance;
    logic carrier_right;
    logic carrier_left;
    logic head_home;
  } cke_console_t;

endpackage

/* bench/cke_kbd_model.sv */
// Operator model: presses one console key at a time
`timescale 1ns/1ps
`default_nettype none
module cke_kbd_model
  import cke_pkg::*;
(
  input  wire logic aclk,
  output var cke_kbd_t kbd_pins
);
  initial kbd_pins = '0;
  // Released code lines show the inverse, so a stale code is never read as held
  task automatic press(input logic [7:0] code, input logic shift);
    @(posedge aclk);
    kbd_pins <= '{1'b1, code, shift, 1'b0};
    repeat (6) @(posedge aclk);
    kbd_pins <= '{1'b0, ~code, 1'b0, 1'b0};
    repeat (12) @(posedge aclk);
  endtask
endmodule // cke_kbd_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the console keyboard entry control
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
  import cke_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, dat, eacc;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] psel_lamp;
  logic [7:0] fk [3] = '{KEY_HUND, KEY_THOU, KEY_SREV};
  cke_kbd_t kbd;
  cke_console_t con;
  int num_errors = 0, cmp_count = 0, ni, nf, tn, home_n = 0, right_n = 0;
  // Short buffer and repeat counts keep the run brief
  cke_keyboard_entry #(.BUF_DEPTH(4), .REPEAT_CYC(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .kbd_pins(kbd), .console(con),
    .psel_lamp(psel_lamp));
  cke_kbd_model i_kbd (.aclk(aclk), .kbd_pins(kbd));
  initial forever #50 aclk = ~aclk;
  // Pulses last one cycle, so they are counted rather than sampled
  always @(posedge aclk) begin
    home_n <= home_n + con.head_home;
    right_n <= right_n + con.carrier_right;
  end
  function automatic logic [31:0] pad(logic [31:0] a, int n);
    return a << (4 * n);
  endfunction
  // One write or read; each channel is released at its own handshake edge
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    if (wr) {awaddr, wdata, awv, wv, bready} <= {a, d, 3'b111};
    else {araddr, arv, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bready && bvalid) {bready, rsp} <= {1'b0, bresp};
      if (arv && arready) arv <= 1'b0;
      if (rready && rvalid) {rready, rsp, dat} <= {1'b0, rresp, rdata};
    end while (awv || wv || bready || arv || rready);
    // Let the answer and the registered outputs of this edge settle before anyone looks
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(95844));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi(0, 8'h14, 0);
    `CHK("unmapped resp", RESP_SLVERR, rsp)
    axi(0, ADDR_PSEL, 0);
    `CHK("psel reset", 32'h0, dat)
    `CHK("console idle", 8'h0, con)
    axi(1, ADDR_PSEL, 32'h0000_0005);
    `CHK("psel lamp", 16'h0005, psel_lamp)
    $display("test reset done");
    // Random digit counts up to both limits, flag keys enabled
    repeat (3) begin
      ni = 1 + $urandom % 3;
      nf = $urandom % 3;
      tn = $urandom % 4;
      eacc = '0;
      axi(1, ADDR_CTRL, 32'h8000_230d);
      for (int i = 0; i < ni + nf + 1; i++) begin
        dat = (i == ni) ? {24'h0, KEY_DEC} : $urandom % 10;
        if (i != ni) eacc = {eacc[27:0], dat[3:0]};
        i_kbd.press(dat[7:0], 1'b0);
      end
      foreach (fk[j]) i_kbd.press(fk[j], 1'b0);
      i_kbd.press(KEY_TERM1 + 8'(tn), 1'b0);
      axi(0, ADDR_ACC, 0);
      `CHK("acc", pad(eacc, 2 - nf), dat)
      axi(0, ADDR_STATUS, 0);
      `CHK("status", {12'h0, 4'h2, ni[3:0], 4'h1 << tn, 8'h38}, dat & 32'h000f_ff3b)
    end
    $display("test numeric done");
    // Overflow, then a key under error, then RESET restarts
    axi(1, ADDR_CTRL, 32'h8000_0201);
    repeat (3) i_kbd.press(8'h07, 1'b0);
    `CHK("overflow", 2'b11, {con.error_lamp, con.alarm_bell})
    i_kbd.press(8'h05, 1'b0);
    `CHK("lamp held", 1'b1, con.error_lamp)
    i_kbd.press(KEY_RESET, 1'b0);
    axi(0, ADDR_ACC, 0);
    `CHK("acc cleared", 32'h0, dat)
    axi(0, ADDR_STATUS, 0);
    `CHK("restarted", 32'h1, dat & 32'h000f_f003)
    foreach (fk[j]) begin
      i_kbd.press(fk[j], 1'b0);
      `CHK("disabled key", 1'b1, con.error_lamp)
      i_kbd.press(KEY_RESET, 1'b0);
    end
    $display("test errors done");
    // Typewriter entry: the first RESET after an error must not home the head
    axi(1, ADDR_CTRL, 32'h8000_0032);
    `CHK("alpha lamp", 1'b1, con.alpha_lamp)
    i_kbd.press(8'h03, 1'b0);
    `CHK("digit rejected", 1'b1, con.error_lamp)
    i_kbd.press(KEY_RESET, 1'b0);
    `CHK("first reset", 33'h0, {con.error_lamp, home_n})
    i_kbd.press(KEY_RESET, 1'b0);
    `CHK("head home", 1, home_n)
    i_kbd.press(KEY_SPACE, 1'b0);
    `CHK("space", 1, right_n)
    i_kbd.press(8'h41, 1'b1);
    axi(1, ADDR_BUF, 1);
    axi(0, ADDR_BUF, 0);
    `CHK("plain char", 8'h41, dat[7:0])
    i_kbd.press(KEY_TW_TERM1, 1'b1);
    axi(0, ADDR_STATUS, 0);
    `CHK("third term", 4'h4, dat[11:8])
    $display("test typewriter done");
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
